// ==== common/uart_fifo_pkg.sv ====
// Purpose: shared constants for the uart byte fifo path
// Assumes: axi4-lite, 32-bit data, word-aligned registers
// Notes:   offsets are byte addresses
package uart_fifo_pkg;
   localparam int          DATA_W        = 8;
   localparam int          FIFO_DEPTH    = 4;
   localparam int          ADDR_W        = 5;
   // register byte offsets
   localparam logic [4:0]  OFS_TX_DATA   = 5'h00;
   localparam logic [4:0]  OFS_RX_DATA   = 5'h04;
   localparam logic [4:0]  OFS_STATUS    = 5'h08;
   localparam logic [4:0]  OFS_IRQ_STAT  = 5'h0C;
   localparam logic [4:0]  OFS_IRQ_CLR   = 5'h10;
   localparam logic [4:0]  OFS_IRQ_EN    = 5'h14;
   localparam logic [4:0]  OFS_CTRL      = 5'h18;
   // status register fields
   localparam int          ST_RX_OVF     = 0;
   localparam int          ST_RX_HAS     = 1;
   localparam int          ST_TX_FULL    = 2;
   localparam int          ST_TX_ROOM    = 3;
   localparam int          ST_TX_DRAINED = 4;
   // interrupt event fields
   localparam int          EV_RX_DATA    = 0;
   localparam int          EV_TX_DRAINED = 1;
   localparam int          EV_RX_OVF     = 2;
   localparam int          EV_W          = 3;
   // control fields
   localparam int          CTRL_TX_EN    = 0;
   localparam logic [0:0]  CTRL_RESET    = 1'h1;
   localparam logic [2:0]  IRQ_EN_RESET  = 3'h0;
   // send permit to start bit, in component clock cycles
   localparam int          PERMIT_MIN_CYC = 1;
   localparam int          PERMIT_MAX_CYC = 2;
   // axi responses
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage

// ==== sim/serializer_model.sv ====
// Purpose: serializer stand-in that ends each frame after a delay
// Assumes: one frame per tx_start pulse
// Notes:   odd bytes take a slow frame, even bytes a prompt one
`timescale 1ns/1ps
module serializer_model (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       tx_start,
   input  wire logic [7:0] tx_byte,
   output logic            tx_frame_done = 1'b0
);
   int left = 0;
   // done is a single-cycle pulse, never held
   always @(posedge clock) begin
      tx_frame_done <= 1'b0;
      if (!rst_n) left <= 0;
      else if (tx_start) left <= tx_byte[0] ? 12 : 3;
      else if (left == 1) begin
         left          <= 0;
         tx_frame_done <= 1'b1;
      end else if (left > 0) left <= left - 1;
   end
endmodule // serializer_model

// ==== sim/tb_uart_data_fifo_path.sv ====
// Purpose: self-checking bench for the uart byte fifo path
// Assumes: serializer model closes every frame
// Notes:   random bytes from a fixed seed, overflow corners by hand
`timescale 1ns/1ps
module tb_uart_data_fifo_path;
   localparam int D = 4;
   logic        clock = 1'b0, rst_n = 1'b0, cts_n = 1'b1, rx_valid = 1'b0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
   logic [31:0] wdata = 32'h0000_0000, rd;
   logic [3:0]  wstrb = 4'hF;
   logic [7:0]  rx_byte = 8'h00, bt, tx_byte;
   logic [1:0]  bresp, rresp, rsp;
   logic        awready, wready, bvalid, arready, rvalid, done, tx_start, drv_en;
   logic        tx_dma, rx_dma, irq;
   logic [31:0] rdata;
   logic [7:0]  exp_q[$], got_q[$];
   int          bad_count = 0, checked = 0, n;

   uart_data_fifo_path #(.DEPTH(D)) u_uart_data_fifo_path (
      .clock(clock), .rst_n(rst_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .clear_to_send_n(cts_n), .tx_frame_done(done), .tx_start(tx_start),
      .tx_byte(tx_byte), .tx_driver_en(drv_en), .rx_byte_valid(rx_valid),
      .rx_byte(rx_byte), .tx_dma_req(tx_dma), .rx_dma_req(rx_dma), .irq(irq));
   serializer_model u_serializer_model (
      .clock(clock), .rst_n(rst_n), .tx_start(tx_start), .tx_byte(tx_byte),
      .tx_frame_done(done));

   initial begin
      forever #20 clock = ~clock;
   end
   always @(posedge clock) if (tx_start === 1'b1) got_q.push_back(tx_byte);

   task automatic close_out;
      $display("counts: %0d checked, %0d bad", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t %s: got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic chkb(input logic got, input logic exp, input string m);
      chk({31'h0, got}, {31'h0, exp}, m);
   endtask
   task automatic wreg(input logic [4:0] a, input logic [31:0] d);
      @(posedge clock);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      rsp = bresp;
      bready <= 1'b0;
      chk(n, 3, "write answer latency");
   endtask
   task automatic rreg(input logic [4:0] a);
      @(posedge clock);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd  = rdata;
      rsp = rresp;
      rready <= 1'b0;
      chk(n, 2, "read answer latency");
   endtask
   function automatic logic [31:0] st_exp(input bit ovf, input int rxn, input int txn);
      st_exp = 32'h0000_0000;
      st_exp[uart_fifo_pkg::ST_RX_OVF]     = ovf;
      st_exp[uart_fifo_pkg::ST_RX_HAS]     = rxn > 0;
      st_exp[uart_fifo_pkg::ST_TX_FULL]    = txn == D;
      st_exp[uart_fifo_pkg::ST_TX_ROOM]    = txn < D;
      st_exp[uart_fifo_pkg::ST_TX_DRAINED] = txn == 0;
   endfunction

   initial begin
      repeat (20000) @(posedge clock);
      bad_count++;
      close_out();
   end

   initial begin
      void'($urandom(32'h51f1));
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      repeat (2) @(posedge clock);
      rreg(uart_fifo_pkg::OFS_STATUS);
      chk(rd, st_exp(0, 0, 0), "status after reset");
      chkb(tx_dma, 1'h1, "tx dma idle");
      chkb(rx_dma | irq, 1'h0, "rx dma, irq idle");
      rreg(uart_fifo_pkg::OFS_CTRL);
      chk(rd, 32'h0000_0001, "control reset");
      rreg(uart_fifo_pkg::OFS_IRQ_EN);
      chk(rd, 32'h0000_0000, "irq enable reset");
      rreg(5'h1C);
      chk({30'h0, rsp}, {30'h0, uart_fifo_pkg::RESP_SLVERR}, "unmapped resp");
      chk(rd, 32'h0000_0000, "unmapped data");
      $display("test reset done");
      // send held off, so one write past full must be dropped
      for (int i = 0; i <= D; i++) begin
         bt = 8'($urandom);
         if (i < D) exp_q.push_back(bt);
         wreg(uart_fifo_pkg::OFS_TX_DATA, {24'h00_0000, bt});
         chk({30'h0, rsp}, {30'h0, uart_fifo_pkg::RESP_OKAY}, "tx write resp");
      end
      rreg(uart_fifo_pkg::OFS_STATUS);
      chk(rd, st_exp(0, 0, D), "tx full status");
      chkb(tx_dma | tx_start, 1'h0, "held while full");
      @(posedge clock);
      cts_n <= 1'b0;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (tx_start !== 1'b1 && n < 5);
      chkb(n >= 2 && n <= 3, 1'h1, "permit to start");
      chkb(drv_en, 1'h1, "driver on at start");
      n = 0;
      while (got_q.size() < D && n < 400) begin
         @(posedge clock);
         n++;
      end
      repeat (40) @(posedge clock);
      chk(got_q.size(), D, "frame count");
      foreach (exp_q[i]) chk({24'h00_0000, got_q[i]}, {24'h00_0000, exp_q[i]}, "tx order");
      chkb(tx_dma, 1'h1, "tx dma when drained");
      chkb(drv_en, 1'h0, "driver off after frames");
      $display("test transmit done");
      wreg(uart_fifo_pkg::OFS_IRQ_EN, 32'h0000_0001);
      exp_q.delete();
      // back-to-back arrivals, the last one overflows
      for (int i = 0; i <= D; i++) begin
         bt = 8'($urandom);
         if (i < D) exp_q.push_back(bt);
         @(posedge clock);
         rx_valid <= 1'b1;
         rx_byte  <= bt;
      end
      @(posedge clock);
      rx_valid <= 1'b0;
      repeat (3) @(posedge clock);
      chkb(rx_dma, 1'h1, "rx dma with data");
      chkb(irq, 1'h1, "rx irq");
      rreg(uart_fifo_pkg::OFS_STATUS);
      chk(rd, st_exp(1, D, 0), "overrun status");
      for (int i = 0; i < D; i++) begin
         rreg(uart_fifo_pkg::OFS_RX_DATA);
         chk(rd, {24'h00_0000, exp_q[i]}, "rx order");
      end
      rreg(uart_fifo_pkg::OFS_STATUS);
      chk(rd, st_exp(0, 0, 0), "overrun cleared by read");
      repeat (3) @(posedge clock);
      chkb(rx_dma, 1'h0, "rx dma drained");
      rreg(uart_fifo_pkg::OFS_IRQ_STAT);
      chk(rd, 32'h0000_0007, "irq events");
      wreg(uart_fifo_pkg::OFS_IRQ_CLR, 32'h0000_0007);
      rreg(uart_fifo_pkg::OFS_IRQ_STAT);
      chk(rd, 32'h0000_0000, "irq events cleared");
      chkb(irq, 1'h0, "irq low after clear");
      $display("test receive done");
      wreg(uart_fifo_pkg::OFS_IRQ_EN, 32'h0000_0000);
      bt = 8'($urandom);
      @(posedge clock);
      rx_valid <= 1'b1;
      rx_byte  <= bt;
      @(posedge clock);
      rx_valid <= 1'b0;
      repeat (4) @(posedge clock);
      chkb(irq, 1'h0, "masked irq");
      rreg(uart_fifo_pkg::OFS_IRQ_STAT);
      chk(rd, 32'h0000_0001, "masked event kept");
      rreg(uart_fifo_pkg::OFS_RX_DATA);
      chk(rd, {24'h00_0000, bt}, "single rx byte");
      $display("test mask done");
      // sending switched off, and a write whose byte strobe is clear
      wreg(uart_fifo_pkg::OFS_CTRL, 32'h0000_0000);
      wstrb <= 4'h0;
      wreg(uart_fifo_pkg::OFS_TX_DATA, 32'h0000_00A5);
      wstrb <= 4'hF;
      rreg(uart_fifo_pkg::OFS_STATUS);
      chk(rd, st_exp(0, 0, 0), "cleared strobe pushes nothing");
      bt = 8'($urandom);
      wreg(uart_fifo_pkg::OFS_TX_DATA, {24'h00_0000, bt});
      repeat (10) @(posedge clock);
      chk(got_q.size(), D, "held while sending disabled");
      wreg(uart_fifo_pkg::OFS_CTRL, 32'h0000_0001);
      repeat (20) @(posedge clock);
      chk(got_q.size(), D + 1, "frame after enable");
      chk({24'h00_0000, got_q[D]}, {24'h00_0000, bt}, "enabled byte");
      $display("test control done");
      close_out();
   end
endmodule // tb_uart_data_fifo_path

// ==== verilog/byte_fifo.sv ====
// Purpose: synchronous byte fifo with push/pop and level flags
// Assumes: push ignored when full, pop ignored when empty
// Notes:   head word is presented combinationally
`timescale 1ns/1ps
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic                       clock,
   input  wire logic                       rst_n,
   input  wire logic                       push,
   input  wire logic [WIDTH-1:0]           push_data,
   input  wire logic                       pop,
   output logic      [WIDTH-1:0]           head_data,
   output logic      [$clog2(DEPTH+1)-1:0] count,
   output logic                            full,
   output logic                            empty
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wr_q;
   logic [PW-1:0]    rd_q;
   logic [CW-1:0]    cnt_q;
   logic             do_push;
   logic             do_pop;

   function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
      ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction

   assign full      = (cnt_q == CW'(DEPTH));
   assign empty     = (cnt_q == '0);
   assign count     = cnt_q;
   assign head_data = mem[rd_q];
   assign do_push   = push && !full;
   assign do_pop    = pop && !empty;

   always_ff @(posedge clock) begin
      if (do_push) begin
         mem[wr_q] <= push_data;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (do_push) begin
            wr_q <= ptr_inc(wr_q);
         end
         if (do_pop) begin
            rd_q <= ptr_inc(rd_q);
         end
         cnt_q <= cnt_q + CW'(do_push) - CW'(do_pop);
      end
   end

   AST_FIFO_NO_OVERFILL : assert property (@(posedge clock) disable iff (!rst_n)
      full && push && !pop |=> full && count == $past(count))
      else $error("fifo count moved on push while full");
endmodule // byte_fifo

// ==== verilog/tx_launcher.sv ====
// Purpose: starts serializer frames from the transmit fifo under flow control
// Assumes: serializer pulses frame_done at the end of each frame
// Notes:   clear_to_send_n low permits sending
`timescale 1ns/1ps
module tx_launcher #(
   parameter int WIDTH = 8
) (
   input  wire logic             clock,
   input  wire logic             rst_n,
   input  wire logic             fifo_empty,
   input  wire logic [WIDTH-1:0] fifo_head,
   input  wire logic             tx_enable,
   input  wire logic             clear_to_send_n,
   input  wire logic             frame_done,
   output logic                  fifo_pop,
   output logic                  tx_start_q,
   output logic      [WIDTH-1:0] tx_byte_q,
   output logic                  driver_en_q
);
   localparam int P_MIN = uart_fifo_pkg::PERMIT_MIN_CYC;
   localparam int P_MAX = uart_fifo_pkg::PERMIT_MAX_CYC;

   typedef enum logic {IDLE, SEND} launch_e;
   launch_e state_q;

   // the frame stays out until done, so a cleared permit never cuts it short
   assign fifo_pop = (state_q == IDLE) && !fifo_empty && tx_enable && !clear_to_send_n;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_q     <= IDLE;
         tx_start_q  <= 1'b0;
         tx_byte_q   <= '0;
         driver_en_q <= 1'b0;
      end else begin
         tx_start_q <= fifo_pop;
         unique case (state_q)
            IDLE: begin
               if (fifo_pop) begin
                  state_q     <= SEND;
                  tx_byte_q   <= fifo_head;
                  driver_en_q <= 1'b1;
               end
            end
            SEND: begin
               if (frame_done) begin
                  state_q     <= IDLE;
                  driver_en_q <= 1'b0;
               end
            end
         endcase
      end
   end

   sequence permit_given_s;
      $fell(clear_to_send_n) && state_q == IDLE && !fifo_empty && tx_enable;
   endsequence

   AST_PERMIT_TO_START : assert property (@(posedge clock) disable iff (!rst_n)
      permit_given_s |-> ##[P_MIN:P_MAX] (tx_start_q && driver_en_q))
      else $error("start bit not launched within permit window");

   AST_NO_START_EMPTY : assert property (@(posedge clock) disable iff (!rst_n)
      tx_start_q |-> !$past(fifo_empty) && !$past(clear_to_send_n))
      else $error("frame started without a queued byte or permit");

   AST_START_WHEN_READY : assert property (@(posedge clock) disable iff (!rst_n)
      state_q == IDLE && !fifo_empty && tx_enable && !clear_to_send_n
      |=> tx_start_q && tx_byte_q == $past(fifo_head))
      else $error("queued byte not launched while permitted");
endmodule // tx_launcher

// ==== verilog/uart_data_fifo_path.sv ====
// Purpose: transmit and receive byte fifos between host bus and uart serializer
// Assumes: axi4-lite slave, one clock, synchronous active-low reset
// Notes:   frame timing lives in the serializer and deserializer
`timescale 1ns/1ps
module uart_data_fifo_path #(
   parameter int DEPTH = uart_fifo_pkg::FIFO_DEPTH
) (
   input  wire logic        clock,
   input  wire logic        rst_n,
   // axi4-lite slave
   input  wire logic [4:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [4:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // serializer side
   input  wire logic        clear_to_send_n,
   input  wire logic        tx_frame_done,
   output logic             tx_start,
   output logic [7:0]       tx_byte,
   output logic             tx_driver_en,
   // deserializer side
   input  wire logic        rx_byte_valid,
   input  wire logic [7:0]  rx_byte,
   // system
   output logic             tx_dma_req,
   output logic             rx_dma_req,
   output logic             irq
);
   localparam int DW = uart_fifo_pkg::DATA_W;
   localparam int CW = $clog2(DEPTH + 1);
   localparam int EW = uart_fifo_pkg::EV_W;

   // bus state
   logic             awready_q;
   logic             wready_q;
   logic             bvalid_q;
   logic [1:0]       bresp_q;
   logic             arready_q;
   logic             rvalid_q;
   logic [1:0]       rresp_q;
   logic [31:0]      rdata_q;
   logic [4:0]       waddr_q;
   logic [31:0]      wdata_q;
   logic [3:0]       wstrb_q;
   logic             wr_commit;
   logic             rd_take;

   // block state
   logic [0:0]       ctrl_q;
   logic             rx_ovf_q;
   logic [EW-1:0]    irq_stat_q;
   logic [EW-1:0]    irq_en_q;
   logic             irq_q;
   logic             tx_dma_q;
   logic             rx_dma_q;

   // fifo wires
   logic [DW-1:0]    tx_head;
   logic [CW-1:0]    tx_count;
   logic             tx_full;
   logic             tx_empty;
   logic             tx_pop;
   logic             tx_push;
   logic [DW-1:0]    rx_head;
   logic [CW-1:0]    rx_count;
   logic             rx_full;
   logic             rx_empty;
   logic             rx_pop;
   logic             rx_push_ok;
   logic             rx_overrun;
   logic             tx_drained_ev;
   logic [EW-1:0]    events;
   logic             irq_clr_we;
   logic [31:0]      status_word;

   function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
      hit = (a[4:2] == ofs[4:2]);
   endfunction

   function automatic logic known(input logic [4:0] a);
      known = hit(a, uart_fifo_pkg::OFS_TX_DATA) || hit(a, uart_fifo_pkg::OFS_RX_DATA)
         || hit(a, uart_fifo_pkg::OFS_STATUS) || hit(a, uart_fifo_pkg::OFS_IRQ_STAT)
         || hit(a, uart_fifo_pkg::OFS_IRQ_CLR) || hit(a, uart_fifo_pkg::OFS_IRQ_EN)
         || hit(a, uart_fifo_pkg::OFS_CTRL);
   endfunction

   // ---------------- axi write channel ----------------
   assign wr_commit = !awready_q && !wready_q && !bvalid_q;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         bvalid_q  <= 1'b0;
         bresp_q   <= uart_fifo_pkg::RESP_OKAY;
         waddr_q   <= '0;
         wdata_q   <= '0;
         wstrb_q   <= '0;
      end else begin
         if (s_axi_awvalid && awready_q) begin
            awready_q <= 1'b0;
            waddr_q   <= s_axi_awaddr;
         end
         if (s_axi_wvalid && wready_q) begin
            wready_q <= 1'b0;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end
         if (wr_commit) begin
            bvalid_q <= 1'b1;
            bresp_q  <= known(waddr_q) ? uart_fifo_pkg::RESP_OKAY : uart_fifo_pkg::RESP_SLVERR;
         end
         if (bvalid_q && s_axi_bready) begin
            bvalid_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
      end
   end

   // a full transmit fifo silently drops the byte; software polls room first
   assign tx_push = wr_commit && wstrb_q[0] && hit(waddr_q, uart_fifo_pkg::OFS_TX_DATA);
   assign irq_clr_we = wr_commit && wstrb_q[0] && hit(waddr_q, uart_fifo_pkg::OFS_IRQ_CLR);

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ctrl_q   <= uart_fifo_pkg::CTRL_RESET;
         irq_en_q <= uart_fifo_pkg::IRQ_EN_RESET;
      end else if (wr_commit && wstrb_q[0]) begin
         if (hit(waddr_q, uart_fifo_pkg::OFS_CTRL)) begin
            ctrl_q <= wdata_q[0:0];
         end
         if (hit(waddr_q, uart_fifo_pkg::OFS_IRQ_EN)) begin
            irq_en_q <= wdata_q[EW-1:0];
         end
      end
   end

   // ---------------- axi read channel ----------------
   assign rd_take = s_axi_arvalid && arready_q;
   // reading the data port pops; an empty fifo reads zero and pops nothing
   assign rx_pop  = rd_take && hit(s_axi_araddr, uart_fifo_pkg::OFS_RX_DATA);

   always_comb begin
      status_word = '0;
      status_word[uart_fifo_pkg::ST_RX_OVF]     = rx_ovf_q;
      status_word[uart_fifo_pkg::ST_RX_HAS]     = !rx_empty;
      status_word[uart_fifo_pkg::ST_TX_FULL]    = tx_full;
      status_word[uart_fifo_pkg::ST_TX_ROOM]    = !tx_full;
      status_word[uart_fifo_pkg::ST_TX_DRAINED] = tx_empty;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rresp_q   <= uart_fifo_pkg::RESP_OKAY;
         rdata_q   <= '0;
      end else begin
         if (rd_take) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rresp_q   <= known(s_axi_araddr) ? uart_fifo_pkg::RESP_OKAY
                                             : uart_fifo_pkg::RESP_SLVERR;
            rdata_q   <= '0;
            if (hit(s_axi_araddr, uart_fifo_pkg::OFS_RX_DATA) && !rx_empty) begin
               rdata_q <= {24'h00_0000, rx_head};
            end else if (hit(s_axi_araddr, uart_fifo_pkg::OFS_STATUS)) begin
               rdata_q <= status_word;
            end else if (hit(s_axi_araddr, uart_fifo_pkg::OFS_IRQ_STAT)) begin
               rdata_q <= {29'h0000_0000, irq_stat_q};
            end else if (hit(s_axi_araddr, uart_fifo_pkg::OFS_IRQ_EN)) begin
               rdata_q <= {29'h0000_0000, irq_en_q};
            end else if (hit(s_axi_araddr, uart_fifo_pkg::OFS_CTRL)) begin
               rdata_q <= {31'h0000_0000, ctrl_q};
            end
         end
         if (rvalid_q && s_axi_rready) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
         end
      end
   end

   // ---------------- fifos and launcher ----------------
   byte_fifo #(.WIDTH(DW), .DEPTH(DEPTH)) u_tx_fifo (
      .clock     (clock),
      .rst_n     (rst_n),
      .push      (tx_push),
      .push_data (wdata_q[DW-1:0]),
      .pop       (tx_pop),
      .head_data (tx_head),
      .count     (tx_count),
      .full      (tx_full),
      .empty     (tx_empty)
   );

   tx_launcher #(.WIDTH(DW)) u_launch (
      .clock           (clock),
      .rst_n           (rst_n),
      .fifo_empty      (tx_empty),
      .fifo_head       (tx_head),
      .tx_enable       (ctrl_q[uart_fifo_pkg::CTRL_TX_EN]),
      .clear_to_send_n (clear_to_send_n),
      .frame_done      (tx_frame_done),
      .fifo_pop        (tx_pop),
      .tx_start_q      (tx_start),
      .tx_byte_q       (tx_byte),
      .driver_en_q     (tx_driver_en)
   );

   assign rx_push_ok = rx_byte_valid && !rx_full;
   assign rx_overrun = rx_byte_valid && rx_full;

   byte_fifo #(.WIDTH(DW), .DEPTH(DEPTH)) u_rx_fifo (
      .clock     (clock),
      .rst_n     (rst_n),
      .push      (rx_push_ok),
      .push_data (rx_byte),
      .pop       (rx_pop),
      .head_data (rx_head),
      .count     (rx_count),
      .full      (rx_full),
      .empty     (rx_empty)
   );

   // ---------------- overrun, dma and interrupts ----------------
   // clear on status read, but a new overrun in that cycle wins
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rx_ovf_q <= 1'b0;
      end else if (rx_overrun) begin
         rx_ovf_q <= 1'b1;
      end else if (rd_take && hit(s_axi_araddr, uart_fifo_pkg::OFS_STATUS)) begin
         rx_ovf_q <= 1'b0;
      end
   end

   assign tx_drained_ev = tx_pop && (tx_count == CW'(1)) && !tx_push;

   always_comb begin
      events = '0;
      events[uart_fifo_pkg::EV_RX_DATA]    = rx_push_ok;
      events[uart_fifo_pkg::EV_TX_DRAINED] = tx_drained_ev;
      events[uart_fifo_pkg::EV_RX_OVF]     = rx_overrun;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         irq_stat_q <= '0;
         irq_q      <= 1'b0;
         tx_dma_q   <= 1'b0;
         rx_dma_q   <= 1'b0;
      end else begin
         irq_stat_q <= (irq_clr_we ? (irq_stat_q & ~wdata_q[EW-1:0]) : irq_stat_q) | events;
         irq_q      <= |(irq_stat_q & irq_en_q);
         tx_dma_q   <= tx_empty;
         rx_dma_q   <= !rx_empty;
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready  = wready_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rresp   = rresp_q;
   assign s_axi_rdata   = rdata_q;
   assign tx_dma_req    = tx_dma_q;
   assign rx_dma_req    = rx_dma_q;
   assign irq           = irq_q;

   // ---------------- checks ----------------
   sequence rx_arrival_s;
      rx_push_ok && irq_en_q[uart_fifo_pkg::EV_RX_DATA];
   endsequence

   sequence no_clear_s;
      !irq_clr_we && irq_en_q[uart_fifo_pkg::EV_RX_DATA];
   endsequence

   AST_TX_PUSH_COUNTS : assert property (@(posedge clock) disable iff (!rst_n)
      tx_push && !tx_full && !tx_pop |=> tx_count == $past(tx_count) + CW'(1))
      else $error("transmit write did not queue a byte");

   AST_TX_DMA_EMPTY : assert property (@(posedge clock) disable iff (!rst_n)
      rst_n && tx_empty |=> tx_dma_req)
      else $error("transmit dma request missing while empty");

   AST_RX_FIRST_OUT : assert property (@(posedge clock) disable iff (!rst_n)
      rx_push_ok && rx_empty |=> rx_head == $past(rx_byte))
      else $error("receive head is not the oldest byte");

   AST_RX_IRQ : assert property (@(posedge clock) disable iff (!rst_n)
      rx_arrival_s ##1 no_clear_s |=> irq)
      else $error("receive interrupt not raised");

   AST_RX_DMA : assert property (@(posedge clock) disable iff (!rst_n)
      !rx_empty ##1 !rx_empty |-> rx_dma_req)
      else $error("receive dma request missing while data held");

   AST_OVERRUN : assert property (@(posedge clock) disable iff (!rst_n)
      rx_byte_valid && rx_full && !rx_pop
      |=> rx_ovf_q && rx_count == $past(rx_count) && rx_head == $past(rx_head))
      else $error("overflow did not keep store and set overrun");

   AST_STATUS_READ : assert property (@(posedge clock) disable iff (!rst_n)
      rd_take && hit(s_axi_araddr, uart_fifo_pkg::OFS_STATUS)
      |=> s_axi_rvalid && s_axi_rdata[4:2] == {$past(tx_empty), !$past(tx_full),
          $past(tx_full)} && s_axi_rdata[1] == !$past(rx_empty))
      else $error("status read does not show live fifo flags");

   AST_OVF_CLEARS : assert property (@(posedge clock) disable iff (!rst_n)
      rx_ovf_q && rd_take && hit(s_axi_araddr, uart_fifo_pkg::OFS_STATUS) && !rx_overrun
      |=> !rx_ovf_q && s_axi_rvalid && s_axi_rdata[uart_fifo_pkg::ST_RX_OVF])
      else $error("overrun flag not cleared by status read");
endmodule // uart_data_fifo_path
